// file: dv/sei_host_model.sv
// Host side model raising one error event a request
`timescale 1ns/1ps
module sei_host_model
  import sei_pkg::*;
(
  input  wire logic         i_go,
  input  wire logic [3:0]   i_sel,
  output sei_pkg::sei_evt_s o_evt
);
  // Event follows the request level, so the bench's falling-edge timing holds
  always_comb begin
    o_evt = i_go ? sei_evt_s'(14'h2000 >> i_sel) : '0;
  end
endmodule

// file: dv/tb.sv
// Self-checking bench for the serial error interrupt block
`timescale 1ns/1ps
module tb;
  import sei_pkg::*;
  logic        i_clk = 0, i_rst_n = 0, i_wr = 0, go = 0, ce = 1;
  logic [3:0]  sel = '0;
  logic [31:0] i_wdata = '0, o_rdata, en, prev = '0;
  logic        o_irq_pin_a, o_irq_pin_b;
  sei_evt_s    evt;
  int          bad_count = 0, n_checks = 0;
  sei_host_model host (.i_go(go), .i_sel(sel), .o_evt(evt));
  sei_serial_error_irq uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_evt(evt),
    .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq_pin_a(o_irq_pin_a),
    .o_irq_pin_b(o_irq_pin_b));
  initial forever #12.5 i_clk = ~i_clk;
  function automatic logic [31:0] flg(int k);
    return 32'h1 << (k < 7 ? 16 + k : 17 + k);
  endfunction
  // Diagnostic flags 24 and 25 have no enable
  function automatic logic [31:0] enb(int k);
    return k < 7 ? 32'h1 << k : (k < 9 ? 32'h0 : 32'h1 << (k + 1));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(negedge i_clk);
    i_wr = 1;
    i_wdata = d;
    @(negedge i_clk);
    i_wr = 0;
    @(negedge i_clk);
  endtask
  task automatic pulse(input int k);
    @(negedge i_clk);
    go = 1;
    sel = 4'(k);
    @(negedge i_clk);
    go = 0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'he075));
    repeat (2) @(negedge i_clk);
    i_rst_n = 1;
    check(o_rdata, SEI_RESET);
    check({30'h0, o_irq_pin_a, o_irq_pin_b}, 32'h0);
    for (int k = 0; k < 14; k++) begin
      en = $urandom & SEI_EN_MASK;
      if (k == 13) en = SEI_EN_MASK;
      pulse(k);
      repeat (2) @(negedge i_clk);
      // Enables from the previous round are still stored
      check(o_rdata, SEI_RESET | prev | flg(k));
      check({30'h0, o_irq_pin_a, o_irq_pin_b}, {30'h0, {2{|(prev & enb(k))}}});
      // Reserved bits and zero flag bits must be ignored
      wr(en | ($urandom & 32'h8080_8380));
      check(o_rdata, en | SEI_RESET | flg(k));
      check({30'h0, o_irq_pin_a, o_irq_pin_b}, {30'h0, {2{|(en & enb(k))}}});
      wr(en | flg(k));
      check(o_rdata, en | SEI_RESET);
      check({30'h0, o_irq_pin_a, o_irq_pin_b}, 32'h0);
      prev = en;
    end
    // Event and clear in one cycle: the event wins
    @(negedge i_clk);
    go = 1;
    sel = 4'(0);
    i_wr = 1;
    i_wdata = SEI_EN_MASK | flg(0);
    @(negedge i_clk);
    go = 0;
    i_wr = 0;
    @(negedge i_clk);
    check(o_rdata, SEI_EN_MASK | SEI_RESET | flg(0));
    check({30'h0, o_irq_pin_a, o_irq_pin_b}, 32'h3);
    // Clock enable low: event and write are both lost
    @(negedge i_clk);
    ce = 0;
    go = 1;
    sel = 4'(13);
    i_wr = 1;
    i_wdata = flg(0);
    @(negedge i_clk);
    go = 0;
    i_wr = 0;
    @(negedge i_clk);
    check(o_rdata, SEI_EN_MASK | SEI_RESET | flg(0));
    ce = 1;
    // Reset in mid-run
    @(negedge i_clk);
    i_rst_n = 0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1;
    check(o_rdata, SEI_RESET);
    check({30'h0, o_irq_pin_a, o_irq_pin_b}, 32'h0);
    pulse(13);
    @(negedge i_clk);
    check(o_rdata, SEI_RESET | flg(13));
    check({30'h0, o_irq_pin_a, o_irq_pin_b}, 32'h0);
    conclude();
  end
endmodule

// file: src/sei_pkg.sv
// Package for the serial port error interrupt block
package sei_pkg;
  localparam int unsigned SEI_W = 32;
  localparam logic [31:0] SEI_RESET    = 32'h0000_0080;
  localparam logic [31:0] SEI_EN_MASK  = 32'h0000_7c7f;
  localparam logic [31:0] SEI_FLG_MASK = 32'h7f7f_0000;
  localparam int unsigned SEI_FLG_LSB  = 16;

  // Flag bit positions in the combined register
  localparam int unsigned B_BREAK   = 16;
  localparam int unsigned B_UCRC    = 17;
  localparam int unsigned B_UTMO    = 18;
  localparam int unsigned B_UFRM    = 19;
  localparam int unsigned B_UNOISE  = 20;
  localparam int unsigned B_URXOVR  = 21;
  localparam int unsigned B_UTXOVR  = 22;
  localparam int unsigned B_SRXFULL = 24;
  localparam int unsigned B_STXEMP  = 25;
  localparam int unsigned B_RDERR   = 26;
  localparam int unsigned B_WRERR   = 27;
  localparam int unsigned B_SCRC    = 28;
  localparam int unsigned B_STXUND  = 29;
  localparam int unsigned B_SRXOVR  = 30;

  typedef struct packed {
    logic brk;
    logic ucrc;
    logic utmo;
    logic ufrm;
    logic unoise;
    logic urxovr;
    logic utxovr;
    logic srxfull;
    logic stxemp;
    logic rderr;
    logic wrerr;
    logic scrc;
    logic stxund;
    logic srxovr;
  } sei_evt_s;

  typedef struct packed {
    logic [SEI_W-1:0] reg_val;
    logic             irq;
  } sei_state_s;
endpackage

// file: src/sei_serial_error_irq.sv
// Serial port error flags, enables and interrupt pins
`timescale 1ns/1ps
module sei_serial_error_irq
  import sei_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_ce,
  input  wire sei_pkg::sei_evt_s     i_evt,
  input  wire logic                  i_wr,
  input  wire logic [31:0]           i_wdata,
  output logic      [31:0]           o_rdata,
  output logic                       o_irq_pin_a,
  output logic                       o_irq_pin_b
);
  import sei_pkg::*;

  sei_state_s st;
  sei_state_s next_st;
  logic [31:0] evt_vec;
  logic [31:0] flags;
  logic [31:0] enables;

  // Event positions follow the register layout, unused bits stay zero
  always_comb begin
    evt_vec = '0;
    evt_vec[B_BREAK]   = i_evt.brk;
    evt_vec[B_UCRC]    = i_evt.ucrc;
    evt_vec[B_SCRC]    = i_evt.scrc;
    evt_vec[B_UTMO]    = i_evt.utmo;
    evt_vec[B_UFRM]    = i_evt.ufrm;
    evt_vec[B_UNOISE]  = i_evt.unoise;
    evt_vec[B_URXOVR]  = i_evt.urxovr;
    evt_vec[B_UTXOVR]  = i_evt.utxovr;
    evt_vec[B_SRXFULL] = i_evt.srxfull;
    evt_vec[B_STXEMP]  = i_evt.stxemp;
    evt_vec[B_RDERR]   = i_evt.rderr;
    evt_vec[B_WRERR]   = i_evt.wrerr;
    evt_vec[B_STXUND]  = i_evt.stxund;
    evt_vec[B_SRXOVR]  = i_evt.srxovr;
  end

  always_comb begin
    next_st = st;
    flags   = st.reg_val & SEI_FLG_MASK;
    // Write-one-to-clear on flags; new event wins over clear
    if (i_wr) begin
      next_st.reg_val = (st.reg_val & ~SEI_EN_MASK) | (i_wdata & SEI_EN_MASK);
      flags           = flags & ~i_wdata;
    end
    flags = (flags | evt_vec) & SEI_FLG_MASK;
    next_st.reg_val = (next_st.reg_val & ~SEI_FLG_MASK) | flags;
    enables = next_st.reg_val & SEI_EN_MASK;
    // Enable n gates flag n+16; pins registered from next state
    next_st.irq = |((enables << SEI_FLG_LSB) & flags);
  end

  // Reset takes priority over the clock enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st.reg_val <= SEI_RESET;
      st.irq     <= 1'b0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_rdata     = st.reg_val;
  assign o_irq_pin_a = st.irq;
  assign o_irq_pin_b = st.irq;

  property p_irq_follows;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce ##1 1'b1 |-> o_irq_pin_a ==
        |(((st.reg_val & SEI_EN_MASK) << SEI_FLG_LSB) & st.reg_val & SEI_FLG_MASK);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

  property p_pins_equal;
    @(posedge i_clk) disable iff (!i_rst_n) o_irq_pin_a == o_irq_pin_b;
  endproperty
  a_pins_equal: assert property (p_pins_equal) else $error("pins differ");

  property p_brk_set;
    @(posedge i_clk) disable iff (!i_rst_n) i_ce && i_evt.brk |=> o_rdata[B_BREAK];
  endproperty
  a_brk_set: assert property (p_brk_set) else $error("break not set");

  property p_crc_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.scrc |=> o_rdata[B_SCRC];
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("spi crc not set");

  property p_tmo_set;
    @(posedge i_clk) disable iff (!i_rst_n) i_ce && i_evt.utmo |=> o_rdata[B_UTMO];
  endproperty
  a_tmo_set: assert property (p_tmo_set) else $error("timeout not set");

  property p_frm_set;
    @(posedge i_clk) disable iff (!i_rst_n) i_ce && i_evt.ufrm |=> o_rdata[B_UFRM];
  endproperty
  a_frm_set: assert property (p_frm_set) else $error("framing not set");

  property p_wr_set;
    @(posedge i_clk) disable iff (!i_rst_n) i_ce && i_evt.wrerr |=> o_rdata[B_WRERR];
  endproperty
  a_wr_set: assert property (p_wr_set) else $error("write err not set");

  property p_sticky;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_rdata[B_SRXOVR] && !(i_ce && i_wr && i_wdata[B_SRXOVR]) |=> o_rdata[B_SRXOVR];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_reserved;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_rdata[31] == 1'b0 && o_rdata[23] == 1'b0 && o_rdata[15] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  // Every event lands one cycle after the edge that takes it
  property p_ucrc_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.ucrc |=> o_rdata[B_UCRC];
  endproperty
  a_ucrc_set: assert property (p_ucrc_set) else $error("uart crc not set");

  property p_noise_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.unoise |=> o_rdata[B_UNOISE];
  endproperty
  a_noise_set: assert property (p_noise_set) else $error("noise not set");

  property p_urxovr_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.urxovr |=> o_rdata[B_URXOVR];
  endproperty
  a_urxovr_set: assert property (p_urxovr_set) else $error("uart rx overrun not set");

  property p_utxovr_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.utxovr |=> o_rdata[B_UTXOVR];
  endproperty
  a_utxovr_set: assert property (p_utxovr_set) else $error("uart tx overrun not set");

  property p_rxfull_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.srxfull |=> o_rdata[B_SRXFULL];
  endproperty
  a_rxfull_set: assert property (p_rxfull_set) else $error("rx full not set");

  property p_txemp_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.stxemp |=> o_rdata[B_STXEMP];
  endproperty
  a_txemp_set: assert property (p_txemp_set) else $error("tx empty not set");

  // Diagnostic flags alone never reach the pins
  property p_diag_quiet;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_rdata & SEI_FLG_MASK & ~((32'h1 << B_SRXFULL) | (32'h1 << B_STXEMP))) == '0
        |-> !o_irq_pin_a;
  endproperty
  a_diag_quiet: assert property (p_diag_quiet) else $error("diag flag on pin");

  property p_rderr_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.rderr |=> o_rdata[B_RDERR];
  endproperty
  a_rderr_set: assert property (p_rderr_set) else $error("read err not set");

  property p_stxund_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.stxund |=> o_rdata[B_STXUND];
  endproperty
  a_stxund_set: assert property (p_stxund_set) else $error("tx underrun not set");

  property p_srxovr_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_evt.srxovr |=> o_rdata[B_SRXOVR];
  endproperty
  a_srxovr_set: assert property (p_srxovr_set) else $error("rx overrun not set");

  property p_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_wr && i_wdata[B_BREAK] && !i_evt.brk |=> !o_rdata[B_BREAK];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_ce_freeze;
    @(posedge i_clk) disable iff (!i_rst_n)
      !i_ce |=> $stable(o_rdata) && $stable(o_irq_pin_a);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

  property p_en_store;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_wr |=> (o_rdata & SEI_EN_MASK) == ($past(i_wdata) & SEI_EN_MASK);
  endproperty
  a_en_store: assert property (p_en_store) else $error("enables not stored");

  property p_en_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_rdata & SEI_EN_MASK) == '0 |-> !o_irq_pin_a;
  endproperty
  a_en_off: assert property (p_en_off) else $error("pin high with no enable");

  property p_rst_val;
    @(posedge i_clk)
      !i_rst_n |=> o_rdata == SEI_RESET && !o_irq_pin_a && !o_irq_pin_b;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset state");
endmodule
